// >>> rtl/bisup_pkg.sv
// Package for the burner input supervisor: register map, fields, states, alerts
package bisup_pkg;

    // ========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LOOP_TRIP = 8'h04;
    localparam logic [7:0] OFS_FUEL_AIR_RATIO_ACTUATOR_CFG = 8'h08;
    localparam logic [7:0] OFS_O2_SET = 8'h0C;
    localparam logic [7:0] OFS_O2_TUNE = 8'h10;
    localparam logic [7:0] OFS_STATE = 8'h14;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
    localparam logic [7:0] OFS_TRIM_OUT = 8'h20;

    // ========================================================
    // Control register fields
    localparam int CTRL_LOOP_SIG = 0;
    localparam int CTRL_FD_FAN = 1;
    localparam int CTRL_WARM_MODE = 2;
    localparam int CTRL_ACK = 4;
    localparam int CTRL_START = 5;
    localparam int CTRL_ADV = 6;

    // Warmup modes
    localparam logic [1:0] WARM_NONE = 2'h0;
    localparam logic [1:0] WARM_TIME = 2'h1;
    localparam logic [1:0] WARM_SENSOR = 2'h2;

    localparam logic [11:0] LOOP_RANGE_LO = 12'h0_0C8;
    localparam logic [11:0] LOOP_RANGE_HI = 12'h0_FA0;
    localparam logic [15:0] WARM_CYCLES = 16'h0_FFF;

    // ========================================================
    // Alert bit positions
    localparam int AL_STUCK = 0;
    localparam int AL_PURGE = 1;
    localparam int AL_RUN = 2;
    localparam int AL_LOOP_INV = 3;
    localparam int AL_LOOP_HI = 4;
    localparam int AL_FUEL_AIR_RATIO_ACTUATOR_INV = 5;
    localparam int AL_FUEL_POS = 6;
    localparam int AL_XLIM = 7;
    localparam int AL_BLEED_CL = 8;
    localparam int AL_BLEED_OP = 9;
    localparam int AL_O2_HIGH = 10;
    localparam int AL_O2_LIMIT = 11;
    localparam int AL_O2_LOW = 12;
    localparam int AL_W = 13;

    typedef enum logic [3:0] {
        ST_READY, ST_ALARM, ST_LOCKOUT, ST_CHECKS, ST_PREPURGE,
        ST_IGNITION, ST_PILOT, ST_LOWFIRE, ST_PROCESS
    } bisup_state_t;

endpackage

// >>> rtl/bisup_top.sv
// Burner input supervisor: field input evaluation, state decisions, Wishbone registers
//
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/1ps

module bisup_top #(
    parameter int LOOP_W = 12,
    parameter int POS_W = 12,
    parameter int TRIM_W = 12
) (
    // System
    input wire logic clk_sys,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // Field inputs
    input wire logic airflow_proof_input,
    input wire logic [LOOP_W-1:0] airflow_loop_level,
    input wire logic [POS_W-1:0] fuel_air_ratio_actuator_pos,
    input wire logic [POS_W-1:0] fuel_air_ratio_actuator_expected,
    input wire logic [POS_W-1:0] fuel_air_ratio_actuator_other,
    input wire logic bleed_valve_open,
    input wire logic [POS_W-1:0] o2_measured,
    input wire logic o2_sensor_warm,
    input wire logic [TRIM_W-1:0] trim_channel_base,
    // Outputs
    output logic safety_outputs_on,
    output logic [TRIM_W-1:0] trim_channel_out,
    output logic trimming,
    output logic irq
);

    // ========================================================
    // State record
    typedef struct packed {
        logic [1:0] af_s;
        logic [1:0] bl_s;
        logic [1:0] o2w_s;
        bisup_pkg::bisup_state_t st;
        logic [6:0] ctrl;
        logic [2*LOOP_W-1:0] trip;
        logic [2*POS_W-1:0] fuel_air_ratio_actuator_cfg;
        logic [3*POS_W-1:0] o2_set;
        logic [3*TRIM_W-1:0] o2_tune;
        logic [bisup_pkg::AL_W-1:0] stat;
        logic [bisup_pkg::AL_W-1:0] mask;
        logic [15:0] warm_cnt;
        logic signed [TRIM_W+7:0] integ;
        logic [TRIM_W-1:0] trim_out;
        logic trimming;
        logic ack;
        logic err;
        logic [31:0] dat;
    } bisup_reg_t;

    bisup_reg_t q_r;
    bisup_reg_t q_nxt;

    function automatic logic [POS_W-1:0] absdiff(input logic [POS_W-1:0] a,
                                                 input logic [POS_W-1:0] b);
        absdiff = (a > b) ? a - b : b - a;
    endfunction

    // ========================================================
    // Decode of present conditions
    logic running;
    logic fuel_st;
    logic main_st;
    logic [LOOP_W-1:0] trip_lo;
    logic [LOOP_W-1:0] trip_hi;
    logic loop_oor;
    logic loop_high;
    logic airflow;
    logic fuel_air_ratio_actuator_inv;
    logic fuel_pos_err;
    logic xlim_err;
    logic warm_done;
    logic [POS_W-1:0] o2_tgt;
    logic [POS_W-1:0] o2_hi;
    logic [POS_W-1:0] o2_lo;
    logic [TRIM_W-1:0] trim_max;
    logic [TRIM_W-1:0] trim_min;
    logic [TRIM_W-1:0] pband;
    logic trim_ok;
    logic [bisup_pkg::AL_W-1:0] alert;
    logic lock_req;
    logic alarm_req;

    always_comb begin
        running = q_r.st inside {bisup_pkg::ST_CHECKS, bisup_pkg::ST_PREPURGE,
            bisup_pkg::ST_IGNITION, bisup_pkg::ST_PILOT, bisup_pkg::ST_LOWFIRE,
            bisup_pkg::ST_PROCESS};
        fuel_st = q_r.st inside {bisup_pkg::ST_IGNITION, bisup_pkg::ST_PILOT,
            bisup_pkg::ST_LOWFIRE, bisup_pkg::ST_PROCESS};
        main_st = q_r.st inside {bisup_pkg::ST_LOWFIRE, bisup_pkg::ST_PROCESS};
        trip_lo = q_r.trip[LOOP_W-1:0];
        trip_hi = q_r.trip[2*LOOP_W-1:LOOP_W];
        loop_oor = q_r.ctrl[bisup_pkg::CTRL_LOOP_SIG] &&
            (airflow_loop_level < LOOP_W'(bisup_pkg::LOOP_RANGE_LO) ||
             airflow_loop_level > LOOP_W'(bisup_pkg::LOOP_RANGE_HI));
        loop_high = q_r.ctrl[bisup_pkg::CTRL_LOOP_SIG] && !loop_oor &&
            airflow_loop_level >= trip_hi;
        // Only this controller's own input is read here
        airflow = q_r.ctrl[bisup_pkg::CTRL_LOOP_SIG] ?
            (airflow_loop_level > trip_lo && airflow_loop_level < trip_hi)
            : q_r.af_s[1];
        fuel_air_ratio_actuator_inv = fuel_air_ratio_actuator_pos < POS_W'(bisup_pkg::LOOP_RANGE_LO) ||
            fuel_air_ratio_actuator_pos > POS_W'(bisup_pkg::LOOP_RANGE_HI);
        fuel_pos_err = !fuel_air_ratio_actuator_inv && absdiff(fuel_air_ratio_actuator_pos,
            fuel_air_ratio_actuator_expected) > q_r.fuel_air_ratio_actuator_cfg[POS_W-1:0];
        xlim_err = absdiff(fuel_air_ratio_actuator_pos, fuel_air_ratio_actuator_other)
            > q_r.fuel_air_ratio_actuator_cfg[2*POS_W-1:POS_W];
        unique case (q_r.ctrl[bisup_pkg::CTRL_WARM_MODE +: 2])
            bisup_pkg::WARM_NONE: warm_done = 1'b1;
            bisup_pkg::WARM_TIME: warm_done = q_r.warm_cnt == bisup_pkg::WARM_CYCLES;
            bisup_pkg::WARM_SENSOR: warm_done = q_r.o2w_s[1];
            default: warm_done = 1'b0;
        endcase
        o2_tgt = q_r.o2_set[POS_W-1:0];
        o2_hi = q_r.o2_set[2*POS_W-1:POS_W];
        o2_lo = q_r.o2_set[3*POS_W-1:2*POS_W];
        pband = q_r.o2_tune[TRIM_W-1:0];
        trim_min = q_r.o2_tune[2*TRIM_W-1:TRIM_W];
        trim_max = q_r.o2_tune[3*TRIM_W-1:2*TRIM_W];
        trim_ok = q_r.st == bisup_pkg::ST_PROCESS && warm_done && o2_measured >= o2_lo;

        alert = '0;
        if (q_r.st == bisup_pkg::ST_CHECKS && airflow) begin
            alert[bisup_pkg::AL_STUCK] = 1'b1;
        end
        if (q_r.st == bisup_pkg::ST_PREPURGE && !airflow) begin
            alert[bisup_pkg::AL_PURGE] = 1'b1;
        end
        if (fuel_st && q_r.ctrl[bisup_pkg::CTRL_FD_FAN] && !airflow) begin
            alert[bisup_pkg::AL_RUN] = 1'b1;
        end
        alert[bisup_pkg::AL_LOOP_INV] = loop_oor;
        alert[bisup_pkg::AL_LOOP_HI] = loop_high;
        alert[bisup_pkg::AL_FUEL_AIR_RATIO_ACTUATOR_INV] = fuel_air_ratio_actuator_inv;
        alert[bisup_pkg::AL_FUEL_POS] = fuel_pos_err;
        alert[bisup_pkg::AL_XLIM] = xlim_err;
        alert[bisup_pkg::AL_BLEED_CL] = !main_st && !q_r.bl_s[1];
        alert[bisup_pkg::AL_BLEED_OP] = main_st && q_r.bl_s[1];
        if (q_r.st == bisup_pkg::ST_PROCESS && warm_done) begin
            alert[bisup_pkg::AL_O2_HIGH] = o2_measured > o2_hi;
            alert[bisup_pkg::AL_O2_LIMIT] = (o2_measured > o2_tgt &&
                q_r.trim_out == trim_max) || (o2_measured < o2_tgt &&
                q_r.trim_out == trim_min);
            alert[bisup_pkg::AL_O2_LOW] = o2_measured < o2_lo;
        end
        // Airflow, loop high, bleed-open and O2 low always lock; O2 high and O2 limit never do; others split by class
        lock_req = |alert[bisup_pkg::AL_RUN:bisup_pkg::AL_STUCK] || loop_high ||
            alert[bisup_pkg::AL_BLEED_OP] || alert[bisup_pkg::AL_O2_LOW] ||
            (running && (loop_oor || fuel_air_ratio_actuator_inv || fuel_pos_err || xlim_err ||
            alert[bisup_pkg::AL_BLEED_CL]));
        alarm_req = loop_oor || fuel_air_ratio_actuator_inv || fuel_pos_err || xlim_err ||
            alert[bisup_pkg::AL_BLEED_CL];
    end

    // ========================================================
    // Next-state logic
    logic hit;
    logic [7:0] off;
    logic signed [TRIM_W+7:0] err_s;
    logic signed [TRIM_W+8:0] sum;

    always_comb begin
        q_nxt = q_r;
        hit = wb_cyc_i && wb_stb_i && !q_r.ack && !q_r.err;
        off = {wb_adr_i[7:2], 2'b00};
        err_s = '0;
        sum = '0;
        q_nxt.af_s = {q_r.af_s[0], airflow_proof_input};
        q_nxt.bl_s = {q_r.bl_s[0], bleed_valve_open};
        q_nxt.o2w_s = {q_r.o2w_s[0], o2_sensor_warm};
        q_nxt.ctrl[bisup_pkg::CTRL_ACK] = 1'b0;
        q_nxt.ctrl[bisup_pkg::CTRL_START] = 1'b0;
        q_nxt.ctrl[bisup_pkg::CTRL_ADV] = 1'b0;
        q_nxt.ack = 1'b0;
        q_nxt.err = 1'b0;

        // Warmup timer runs only while in process control
        if (q_r.st != bisup_pkg::ST_PROCESS) begin
            q_nxt.warm_cnt = '0;
        end else if (q_r.warm_cnt != bisup_pkg::WARM_CYCLES) begin
            q_nxt.warm_cnt = q_r.warm_cnt + 16'h0_001;
        end

        // Trim: PI offset on the trim channel, clamped to table limits
        q_nxt.trimming = trim_ok && o2_measured != o2_tgt;
        if (q_nxt.trimming) begin
            err_s = (TRIM_W+8)'($signed({1'b0, o2_measured})) -
                (TRIM_W+8)'($signed({1'b0, o2_tgt}));
            q_nxt.integ = q_r.integ + (err_s >>> q_r.o2_tune[3:0]);
            sum = (TRIM_W+9)'(q_r.integ) + (TRIM_W+9)'(err_s * $signed({1'b0, pband[3:0]}));
            if (sum > (TRIM_W+9)'($signed({1'b0, trim_max}))) begin
                q_nxt.trim_out = trim_max;
            end else if (sum < (TRIM_W+9)'($signed({1'b0, trim_min}))) begin
                q_nxt.trim_out = trim_min;
            end else begin
                q_nxt.trim_out = TRIM_W'(sum);
            end
        end else if (!trim_ok) begin
            q_nxt.integ = '0;
        end

        // Controller state decisions
        unique case (q_r.st)
            bisup_pkg::ST_READY: begin
                if (alarm_req) begin
                    q_nxt.st = bisup_pkg::ST_ALARM;
                end else if (q_r.ctrl[bisup_pkg::CTRL_START]) begin
                    q_nxt.st = bisup_pkg::ST_CHECKS;
                end
            end
            bisup_pkg::ST_ALARM: begin
                if (!alarm_req) begin
                    q_nxt.st = bisup_pkg::ST_READY;
                end
            end
            bisup_pkg::ST_LOCKOUT: begin
                if (q_r.ctrl[bisup_pkg::CTRL_ACK]) begin
                    q_nxt.st = bisup_pkg::ST_READY;
                end
            end
            bisup_pkg::ST_CHECKS: begin
                if (lock_req) begin
                    q_nxt.st = bisup_pkg::ST_LOCKOUT;
                end else begin
                    q_nxt.st = bisup_pkg::ST_PREPURGE;
                end
            end
            default: begin
                if (lock_req) begin
                    q_nxt.st = bisup_pkg::ST_LOCKOUT;
                end else if (q_r.ctrl[bisup_pkg::CTRL_ADV] &&
                             q_r.st != bisup_pkg::ST_PROCESS) begin
                    q_nxt.st = bisup_pkg::bisup_state_t'(q_r.st + 4'h1);
                end
            end
        endcase
        // High trip locks out from every state, stopped ones included
        if (loop_high) begin
            q_nxt.st = bisup_pkg::ST_LOCKOUT;
        end
        if (q_nxt.st == bisup_pkg::ST_LOCKOUT) begin
            q_nxt.trimming = 1'b0;
        end

        // Sticky alerts, set wins over write-one-to-clear
        q_nxt.stat = q_r.stat;
        if (hit && wb_we_i && off == bisup_pkg::OFS_IRQ_STAT && wb_sel_i[0]) begin
            q_nxt.stat[7:0] = q_r.stat[7:0] & ~wb_dat_i[7:0];
        end
        if (hit && wb_we_i && off == bisup_pkg::OFS_IRQ_STAT && wb_sel_i[1]) begin
            q_nxt.stat[bisup_pkg::AL_W-1:8] = q_r.stat[bisup_pkg::AL_W-1:8] &
                ~wb_dat_i[bisup_pkg::AL_W-1:8];
        end
        q_nxt.stat = q_nxt.stat | alert;

        // Register bus
        if (hit) begin
            q_nxt.ack = 1'b1;
            q_nxt.dat = '0;
            unique case (off)
                bisup_pkg::OFS_CTRL: begin
                    q_nxt.dat = 32'(q_r.ctrl[3:0]);
                    if (wb_we_i && wb_sel_i[0]) begin
                        q_nxt.ctrl = wb_dat_i[6:0];
                    end
                end
                bisup_pkg::OFS_LOOP_TRIP: begin
                    q_nxt.dat = 32'(q_r.trip);
                    if (wb_we_i) begin
                        q_nxt.trip = wb_dat_i[2*LOOP_W-1:0];
                    end
                end
                bisup_pkg::OFS_FUEL_AIR_RATIO_ACTUATOR_CFG: begin
                    q_nxt.dat = 32'(q_r.fuel_air_ratio_actuator_cfg);
                    if (wb_we_i) begin
                        q_nxt.fuel_air_ratio_actuator_cfg = wb_dat_i[2*POS_W-1:0];
                    end
                end
                // Top four bits of the 36-bit setting words lie past the bus and stay zero
                bisup_pkg::OFS_O2_SET: begin
                    q_nxt.dat = 32'(q_r.o2_set);
                    if (wb_we_i) begin
                        q_nxt.o2_set = (3*POS_W)'(wb_dat_i);
                    end
                end
                bisup_pkg::OFS_O2_TUNE: begin
                    q_nxt.dat = 32'(q_r.o2_tune);
                    if (wb_we_i) begin
                        q_nxt.o2_tune = (3*TRIM_W)'(wb_dat_i);
                    end
                end
                bisup_pkg::OFS_STATE: begin
                    q_nxt.dat = {27'h000_0000, q_r.trimming, q_r.st};
                end
                bisup_pkg::OFS_IRQ_STAT: begin
                    q_nxt.dat = 32'(q_r.stat);
                end
                bisup_pkg::OFS_IRQ_MASK: begin
                    q_nxt.dat = 32'(q_r.mask);
                    if (wb_we_i) begin
                        q_nxt.mask = wb_dat_i[bisup_pkg::AL_W-1:0];
                    end
                end
                bisup_pkg::OFS_TRIM_OUT: begin
                    q_nxt.dat = 32'(q_r.trim_out);
                end
                default: begin
                    q_nxt.ack = 1'b0;
                    q_nxt.err = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    // ========================================================
    // Outputs
    assign wb_dat_o = q_r.dat;
    assign wb_ack_o = q_r.ack;
    assign wb_err_o = q_r.err;
    assign safety_outputs_on = running;
    assign trim_channel_out = trim_channel_base + (q_r.trimming ? q_r.trim_out : '0);
    assign trimming = q_r.trimming;
    assign irq = |(q_r.stat & q_r.mask);

    // ========================================================
    // Checks
    sequence s_checks_airflow;
        q_r.st == bisup_pkg::ST_CHECKS && airflow;
    endsequence
    property p_stuck;
        @(posedge clk_sys) disable iff (!rst_n)
        s_checks_airflow |=> q_r.st == bisup_pkg::ST_LOCKOUT;
    endproperty
    a_stuck: assert property (p_stuck) else $error("Stuck airflow not locked out");
    property p_purge_loss;
        @(posedge clk_sys) disable iff (!rst_n)
        q_r.st == bisup_pkg::ST_PREPURGE && !airflow |=> q_r.st == bisup_pkg::ST_LOCKOUT;
    endproperty
    a_purge_loss: assert property (p_purge_loss) else $error("Purge loss missed");
    property p_fd_fan;
        @(posedge clk_sys) disable iff (!rst_n)
        fuel_st && q_r.ctrl[bisup_pkg::CTRL_FD_FAN] && !airflow |=>
            q_r.st == bisup_pkg::ST_LOCKOUT && q_r.stat[bisup_pkg::AL_RUN];
    endproperty
    a_fd_fan: assert property (p_fd_fan) else $error("Run airflow loss missed");
    property p_running_err;
        @(posedge clk_sys) disable iff (!rst_n)
        running && (fuel_air_ratio_actuator_inv || xlim_err) |=> q_r.st == bisup_pkg::ST_LOCKOUT;
    endproperty
    a_running_err: assert property (p_running_err) else $error("No lockout");
    property p_alarm_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        q_r.st == bisup_pkg::ST_ALARM && alarm_req && !loop_high |=>
            q_r.st == bisup_pkg::ST_ALARM;
    endproperty
    a_alarm_hold: assert property (p_alarm_hold) else $error("Alarm left early");
    property p_bleed_main;
        @(posedge clk_sys) disable iff (!rst_n)
        main_st && q_r.bl_s[1] |=> q_r.st == bisup_pkg::ST_LOCKOUT;
    endproperty
    a_bleed_main: assert property (p_bleed_main) else $error("Bleed open missed");
    property p_no_trim;
        @(posedge clk_sys) disable iff (!rst_n)
        q_r.st != bisup_pkg::ST_PROCESS |=> !q_r.trimming;
    endproperty
    a_no_trim: assert property (p_no_trim) else $error("Trim outside process");
    property p_sticky;
        @(posedge clk_sys) disable iff (!rst_n)
        alert[bisup_pkg::AL_XLIM] |=> q_r.stat[bisup_pkg::AL_XLIM] ##1 (irq || !q_r.mask[7]);
    endproperty
    a_sticky: assert property (p_sticky) else $error("Alert not latched");

endmodule

// >>> bench/bisup_field_model.sv
// Field-side model: airflow contact, loop transmitter, actuator feedback, bleed contact
`timescale 1ns/1ps
module bisup_field_model (
    // Clock
    input wire logic clk_sys,
    // Commanded field conditions
    input wire logic air_cmd,
    input wire logic bleed_cmd,
    input wire logic [11:0] lvl_cmd,
    input wire logic [11:0] pos_cmd,
    input wire logic [11:0] oth_cmd,
    // Field signals
    output logic af_in,
    output logic bv_in,
    output logic [11:0] af_lvl,
    output logic [11:0] af_pos,
    output logic [11:0] af_oth
);
    // ========================================================
    // Sensors
    // One airflow source, wired to this controller alone
    always_ff @(posedge clk_sys) begin
        af_in <= air_cmd;
        bv_in <= bleed_cmd;
        af_lvl <= lvl_cmd;
        af_pos <= pos_cmd;
        af_oth <= oth_cmd;
    end
endmodule

// >>> bench/test_burner_input_supervisor.sv
// Testbench for the burner input supervisor: bus tasks and scenario sequence
`timescale 1ns/1ps
module test_burner_input_supervisor;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, air = 1'b0, bleed = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat, cfg, dat_o;
    logic ack, berr, irq, son, af_in, bv_in, rerr, trm;
    logic [11:0] lvl = 12'h7D0, pos = 12'h7D0, oth = 12'h7D0;
    logic [11:0] af_lvl, af_pos, af_oth, trim_o;
    logic [11:0] fp [4] = '{12'h050, 12'h835, 12'h7D0, 12'h834};
    logic [11:0] fo [4] = '{12'h050, 12'h835, 12'h8A0, 12'h834};
    int fb [3] = '{bisup_pkg::AL_FUEL_AIR_RATIO_ACTUATOR_INV, bisup_pkg::AL_FUEL_POS, bisup_pkg::AL_XLIM};
    int err_total = 0, n_checks = 0, cyc_cnt = 0;

    always #25 clk_sys = ~clk_sys;

    bisup_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .wb_err_o(berr), .airflow_proof_input(af_in),
        .airflow_loop_level(af_lvl), .fuel_air_ratio_actuator_pos(af_pos),
        .fuel_air_ratio_actuator_expected(12'h7D0), .fuel_air_ratio_actuator_other(af_oth),
        .bleed_valve_open(bv_in), .o2_measured(12'h7D0), .o2_sensor_warm(1'b0),
        .trim_channel_base(12'h400), .safety_outputs_on(son), .trim_channel_out(trim_o),
        .trimming(trm), .irq(irq));

    bisup_field_model field (.clk_sys(clk_sys), .air_cmd(air), .bleed_cmd(bleed),
        .lvl_cmd(lvl), .pos_cmd(pos), .oth_cmd(oth), .af_in(af_in), .bv_in(bv_in),
        .af_lvl(af_lvl), .af_pos(af_pos), .af_oth(af_oth));

    // ========================================================
    // Tasks
    // Request held until the edge that sees ack or err; one idle cycle follows
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_sys);
        end while (ack !== 1'b1 && berr !== 1'b1);
        rdat = dat_o;
        rerr = berr;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Decisions pass through input synchronisers, so poll under a bound
    task automatic st(input bisup_pkg::bisup_state_t s);
        for (int i = 0; i < 40; i++) begin
            bus(1'b0, bisup_pkg::OFS_STATE, 32'h0000_0000);
            if (rdat[3:0] === s)
                break;
        end
        chk("state", 32'(s), rdat & 32'h0000_000F);
    endtask

    task automatic bit_on(input int b);
        bus(1'b0, bisup_pkg::OFS_IRQ_STAT, 32'h0000_0000);
        chk("alert", 32'h0000_0001, 32'(rdat[b]));
    endtask

    task automatic clr;
        bus(1'b1, bisup_pkg::OFS_CTRL, cfg | 32'h0000_0010);
        bus(1'b1, bisup_pkg::OFS_IRQ_STAT, 32'h0000_1FFF);
        st(bisup_pkg::ST_READY);
    endtask

    task automatic conclude;
        $display("Checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            err_total++;
            conclude();
        end
    end

    // ========================================================
    // Scenarios
    initial begin
        cfg = 32'h0000_0002;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        bus(1'b1, bisup_pkg::OFS_LOOP_TRIP, 32'h00BB_83E8);
        bus(1'b1, bisup_pkg::OFS_FUEL_AIR_RATIO_ACTUATOR_CFG, 32'h000C_8064);
        st(bisup_pkg::ST_READY);
        bus(1'b0, 8'hFC, 32'h0000_0000);
        chk("unmapped", 32'h0000_0001, 32'(rerr));
        bus(1'b1, bisup_pkg::OFS_CTRL, cfg | 32'h0000_0020);
        st(bisup_pkg::ST_LOCKOUT);
        bit_on(bisup_pkg::AL_PURGE);
        bus(1'b1, bisup_pkg::OFS_IRQ_MASK, 32'h0000_0002);
        chk("irq", 32'h0000_0001, 32'(irq));
        bus(1'b1, bisup_pkg::OFS_IRQ_STAT, 32'h0000_0002);
        chk("irq", 32'h0000_0000, 32'(irq));
        bus(1'b1, bisup_pkg::OFS_IRQ_MASK, 32'h0000_0000);
        clr();
        air <= 1'b1;
        bus(1'b1, bisup_pkg::OFS_CTRL, cfg | 32'h0000_0020);
        st(bisup_pkg::ST_LOCKOUT);
        bit_on(bisup_pkg::AL_STUCK);
        air <= 1'b0;
        clr();
        cfg = 32'h0000_0003;
        lvl <= 12'hBB8;
        bus(1'b1, bisup_pkg::OFS_CTRL, cfg);
        st(bisup_pkg::ST_LOCKOUT);
        bit_on(bisup_pkg::AL_LOOP_HI);
        lvl <= 12'h064;
        bus(1'b1, bisup_pkg::OFS_CTRL, cfg | 32'h0000_0010);
        st(bisup_pkg::ST_ALARM);
        bit_on(bisup_pkg::AL_LOOP_INV);
        lvl <= 12'h7D0;
        clr();
        for (int i = 0; i < 4; i++) begin
            pos <= fp[i];
            oth <= fo[i];
            if (i < 3) begin
                st(bisup_pkg::ST_ALARM);
                bit_on(fb[i]);
                pos <= 12'h7D0;
                oth <= 12'h7D0;
            end
            clr();
        end
        bus(1'b0, bisup_pkg::OFS_IRQ_STAT, 32'h0000_0000);
        chk("alerts", 32'h0000_0000, rdat);
        bleed <= 1'b0;
        st(bisup_pkg::ST_ALARM);
        bit_on(bisup_pkg::AL_BLEED_CL);
        chk("outputs", 32'h0000_0000, 32'(son));
        bleed <= 1'b1;
        clr();
        // Run up to process control: airflow proven only from pre-purge on,
        // bleed contact drops just as the main state is entered
        cfg = 32'h0000_0001;
        bus(1'b1, bisup_pkg::OFS_O2_SET, 32'h1080_0700);
        bus(1'b1, bisup_pkg::OFS_O2_TUNE, 32'h0500_0002);
        lvl <= 12'h320;
        bus(1'b1, bisup_pkg::OFS_CTRL, cfg | 32'h0000_0020);
        lvl <= 12'h7D0;
        st(bisup_pkg::ST_PREPURGE);
        for (int i = 0; i < 4; i++) begin
            if (i == 2)
                bleed <= 1'b0;
            bus(1'b1, bisup_pkg::OFS_CTRL, cfg | 32'h0000_0040);
        end
        st(bisup_pkg::ST_PROCESS);
        chk("trim flag", 32'h0000_0001, 32'(rdat[4]));
        chk("trimming", 32'h0000_0001, 32'(trm));
        chk("trim out", 32'h0000_0405, 32'(trim_o));
        bit_on(bisup_pkg::AL_O2_LIMIT);
        bleed <= 1'b1;
        st(bisup_pkg::ST_LOCKOUT);
        bit_on(bisup_pkg::AL_BLEED_OP);
        chk("trimming", 32'h0000_0000, 32'(trm));
        chk("trim out", 32'h0000_0400, 32'(trim_o));
        clr();
        conclude();
    end
endmodule
